/* File: src/srw_pkg.sv */
// Purpose: Shared constants, pin bundles and state codes for the supervisor block.
// Assumes: A 25 MHz reference clock and a one millisecond internal tick.
// Notes:   All times are held in their own unit and turned into counts here.
package srw_pkg;

	localparam int CLK_PERIOD_NS  = 40;
	localparam int TICK_PERIOD_NS = 1000000;
	// A tick never comes early, so the cycle count rounds up.
	localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_MS        = 1;

	localparam int WDOG_MS        = 1600;
	localparam int RST_TIMEOUT_MS = 200;
	localparam int DEBOUNCE_MS    = 10;
	localparam int WDOG_TICKS     = WDOG_MS / TICK_MS;
	localparam int RST_TICKS      = (RST_TIMEOUT_MS + TICK_MS - 1) / TICK_MS;
	localparam int DEBOUNCE_TICKS = (DEBOUNCE_MS + TICK_MS - 1) / TICK_MS;

	localparam int TMR_W          = 11;
	localparam int DB_W           = 4;

	localparam int MEM_BITS       = 2048;
	localparam int BYTE_W         = 8;
	localparam int MEM_DEPTH      = MEM_BITS / BYTE_W;
	localparam int ADDR_W         = 8;
	localparam int PAGE_BYTES     = 16;
	localparam int OFF_W          = 4;
	localparam int PAGE_W         = ADDR_W - OFF_W;

	typedef struct packed {
		logic supply_low;
		logic manual_reset_n_in;
		logic reset_n_pin;
		logic watchdog_kick_in;
		logic sda;
		logic write_protect;
	} srw_pins_s;

	typedef struct packed {
		logic rst_hi_out;
		logic rst_hi_oe;
		logic rst_n_out;
		logic rst_n_oe;
	} srw_rst_s;

	typedef enum logic [2:0] {
		ST_ASSERT = 3'h1,
		ST_HOLD   = 3'h2,
		ST_RUN    = 3'h4
	} srw_state_e;

	// Idle pin levels: supply good, buttons released, lines pulled high, no protect.
	localparam srw_pins_s PINS_IDLE = 6'h1A;
	// During reset both outputs are driven to their active levels.
	localparam srw_rst_s  RST_OUT_INIT = 4'hD;

endpackage

/* File: src/srw_debounce.sv */
// Purpose: Debounces one slow input using the shared millisecond tick.
// Assumes: The input is already synchronised to the clock.
// Notes:   A new level is taken only after it has held for the full debounce time.
`timescale 1ns/1ns
module srw_debounce #(
	parameter int           DB_TICKS = srw_pkg::DEBOUNCE_TICKS,
	parameter logic         INIT     = 1'b1
) (
	input  wire logic i_ref_clk,
	input  wire logic i_rst,
	input  wire logic i_tick,
	input  wire logic i_raw,
	output logic      o_level
);

	logic [srw_pkg::DB_W-1:0] cnt_q;
	logic [srw_pkg::DB_W-1:0] cnt_d;
	logic                     level_q;
	logic                     level_d;

	always_comb
	begin
		cnt_d   = cnt_q;
		level_d = level_q;
		if (i_raw == level_q)
			cnt_d = '0;
		else if (i_tick)
		begin
			if (cnt_q == srw_pkg::DB_W'(DB_TICKS - 1))
			begin
				level_d = i_raw;
				cnt_d   = '0;
			end
			else
				cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			cnt_q   <= '0;
			level_q <= INIT;
		end
		else
		begin
			cnt_q   <= cnt_d;
			level_q <= level_d;
		end
	end

	assign o_level = level_q;

	a_db_settle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$changed(level_q) |-> $past(cnt_q) == srw_pkg::DB_W'(DB_TICKS - 1))
		else $error("debounced level changed before the debounce time");

endmodule

/* File: src/srw_mem.sv */
// Purpose: Byte-wide storage array with one write port and a registered read port.
// Assumes: Write and read share the clock; read data appear one cycle after the address.
// Notes:   Contents are not cleared by reset.
`timescale 1ns/1ns
module srw_mem #(
	parameter int W     = srw_pkg::BYTE_W,
	parameter int DEPTH = srw_pkg::MEM_DEPTH,
	parameter int AW    = srw_pkg::ADDR_W
) (
	input  wire logic          i_ref_clk,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [W-1:0]  i_wdata,
	input  wire logic [AW-1:0] i_raddr,
	output logic      [W-1:0]  o_rdata
);

	logic [W-1:0] mem_q [DEPTH];
	logic [W-1:0] rdata_q;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_we)
			mem_q[i_waddr] <= i_wdata;
		rdata_q <= mem_q[i_raddr];
	end

	assign o_rdata = rdata_q;

endmodule

/* File: src/srw_supervisor.sv */
// Purpose: Supervisor reset, watchdog and write gating for a small serial memory.
// Assumes: Pin inputs are asynchronous; write requests come from logic on this clock.
// Notes:   The low reset pin cannot see an outside pull while this block drives it.
//
// Overview of operation
// - Reset outputs go active when no kick edge arrives within 1.6 seconds.
// - Either kick edge restarts the watchdog; the controller must toggle each interval.
// - Optionally the serial data line serves as the watchdog activity source.
// - Both reset outputs are active while supply-low is reported.
// - Reset stays active 200 ms after supply recovers, then releases.
// - Manual reset input is debounced before use.
// - Debounced low manual reset input causes a reset condition.
// - Reset holds while manual input low, then for the full timeout.
// - Outside low on the reset pin starts, holds, then times out reset; the pull is masked once driven, so the timeout runs from its start.
// - High write-protect refuses all array writes, except in reset and two cycles after; low permits them.
// - Writes are blocked while supply is low, except in reset and two cycles after, while the synchroniser still shows supply good.
// - Array holds 2k bits; writes wrap within 16-byte pages.
`timescale 1ns/1ns
module srw_supervisor #(
	parameter int TICK_CYCLES = srw_pkg::TICK_CYCLES,
	parameter bit WDOG_ON_SDA = 1'b0
) (
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_rst,
	input  wire srw_pkg::srw_pins_s          i_pins,
	input  wire logic                        i_wr_start,
	input  wire logic [srw_pkg::ADDR_W-1:0]  i_wr_addr,
	input  wire logic                        i_wr_valid,
	input  wire logic [srw_pkg::BYTE_W-1:0]  i_wr_data,
	input  wire logic [srw_pkg::ADDR_W-1:0]  i_rd_addr,
	output srw_pkg::srw_rst_s                o_rst,
	output logic                             o_wr_done,
	output logic                             o_wr_refused,
	output logic [srw_pkg::BYTE_W-1:0]       o_rd_data
);

	localparam int PRESC_W = $clog2(TICK_CYCLES);
	localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICK_CYCLES - 1);
	localparam logic [srw_pkg::TMR_W-1:0] WDOG_LAST = srw_pkg::TMR_W'(srw_pkg::WDOG_TICKS - 1);
	localparam logic [srw_pkg::TMR_W-1:0] RST_LAST  = srw_pkg::TMR_W'(srw_pkg::RST_TICKS - 1);

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	// Two-stage synchroniser; stage one feeds stage two only.
	srw_pkg::srw_pins_s pins_s1_q;
	srw_pkg::srw_pins_s pins_s2_q;
	logic               act_s3_q;
	logic               act_s2;
	logic               kick;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			pins_s1_q <= srw_pkg::PINS_IDLE;
			pins_s2_q <= srw_pkg::PINS_IDLE;
			// The edge detector starts at the source's idle level, so reset makes no false kick.
			act_s3_q  <= WDOG_ON_SDA ? srw_pkg::PINS_IDLE.sda : srw_pkg::PINS_IDLE.watchdog_kick_in;
		end
		else
		begin
			pins_s1_q <= i_pins;
			pins_s2_q <= pins_s1_q;
			act_s3_q  <= act_s2;
		end
	end

	assign act_s2 = WDOG_ON_SDA ? pins_s2_q.sda : pins_s2_q.watchdog_kick_in;
	assign kick   = act_s2 ^ act_s3_q;

	// Shared millisecond tick.
	logic [PRESC_W-1:0] presc_q;
	logic [PRESC_W-1:0] presc_d;
	logic               tick;
	logic               restart;

	always_comb
	begin
		// The tick may not depend on restart, since a tick can itself cause the restart.
		tick    = (presc_q == PRESC_LAST);
		presc_d = (restart || tick) ? '0 : presc_q + 1'b1;
	end

	logic mr_level;

	srw_debounce #(
		.DB_TICKS (srw_pkg::DEBOUNCE_TICKS),
		.INIT     (1'b1)
	) u_mr_db (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_tick    (tick),
		.i_raw     (pins_s2_q.manual_reset_n_in),
		.o_level   (mr_level)
	);

	// Own drive history masks the pin's echo through the synchroniser.
	logic [2:0] drv_hist_q;
	logic       ext_low;
	logic       cause;

	assign ext_low = !pins_s2_q.reset_n_pin && (drv_hist_q == 3'h0) && !o_rst.rst_n_oe;
	assign cause   = pins_s2_q.supply_low || !mr_level || ext_low;

	srw_pkg::srw_state_e              state_q;
	srw_pkg::srw_state_e              state_d;
	logic [srw_pkg::TMR_W-1:0]        tmr_q;
	logic [srw_pkg::TMR_W-1:0]        tmr_d;
	srw_pkg::srw_rst_s                rst_q;
	srw_pkg::srw_rst_s                rst_d;

	always_comb
	begin
		state_d = state_q;
		tmr_d   = tmr_q;
		unique case (state_q)
			srw_pkg::ST_ASSERT:
			begin
				tmr_d = '0;
				if (!cause)
					state_d = srw_pkg::ST_HOLD;
			end
			srw_pkg::ST_HOLD:
			begin
				if (cause)
				begin
					state_d = srw_pkg::ST_ASSERT;
					tmr_d   = '0;
				end
				else if (tick)
				begin
					if (tmr_q == RST_LAST)
					begin
						state_d = srw_pkg::ST_RUN;
						tmr_d   = '0;
					end
					else
						tmr_d = tmr_q + 1'b1;
				end
			end
			srw_pkg::ST_RUN:
			begin
				if (cause)
				begin
					state_d = srw_pkg::ST_ASSERT;
					tmr_d   = '0;
				end
				else if (kick)
					tmr_d = '0;
				else if (tick)
				begin
					if (tmr_q == WDOG_LAST)
					begin
						state_d = srw_pkg::ST_HOLD;
						tmr_d   = '0;
					end
					else
						tmr_d = tmr_q + 1'b1;
				end
			end
			default:
			begin
				state_d = srw_pkg::ST_ASSERT;
				tmr_d   = '0;
			end
		endcase
		restart = (state_d != state_q) || (state_q == srw_pkg::ST_RUN && kick);
		rst_d.rst_hi_out = 1'b1;
		rst_d.rst_hi_oe  = (state_d != srw_pkg::ST_RUN);
		rst_d.rst_n_out  = 1'b0;
		rst_d.rst_n_oe   = (state_d != srw_pkg::ST_RUN);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			state_q    <= srw_pkg::ST_ASSERT;
			tmr_q      <= '0;
			presc_q    <= '0;
			rst_q      <= srw_pkg::RST_OUT_INIT;
			drv_hist_q <= 3'h7;
		end
		else
		begin
			state_q    <= state_d;
			tmr_q      <= tmr_d;
			presc_q    <= presc_d;
			rst_q      <= rst_d;
			drv_hist_q <= {drv_hist_q[1:0], rst_q.rst_n_oe};
		end
	end

	assign o_rst = rst_q;

	// Write path with page rollover.
	logic [srw_pkg::PAGE_W-1:0] page_q;
	logic [srw_pkg::PAGE_W-1:0] page_d;
	logic [srw_pkg::OFF_W-1:0]  off_q;
	logic [srw_pkg::OFF_W-1:0]  off_d;
	logic                       wr_allow;
	logic                       mem_we;
	logic                       done_q;
	logic                       done_d;
	logic                       refused_q;
	logic                       refused_d;

	always_comb
	begin
		wr_allow  = !pins_s2_q.write_protect && !pins_s2_q.supply_low;
		mem_we    = i_wr_valid && wr_allow;
		page_d    = page_q;
		off_d     = off_q;
		done_d    = mem_we;
		refused_d = i_wr_valid && !wr_allow;
		if (i_wr_start)
		begin
			page_d = i_wr_addr[srw_pkg::ADDR_W-1:srw_pkg::OFF_W];
			off_d  = i_wr_addr[srw_pkg::OFF_W-1:0];
		end
		else if (mem_we)
			off_d = off_q + 1'b1;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			page_q    <= '0;
			off_q     <= '0;
			done_q    <= 1'b0;
			refused_q <= 1'b0;
		end
		else
		begin
			page_q    <= page_d;
			off_q     <= off_d;
			done_q    <= done_d;
			refused_q <= refused_d;
		end
	end

	assign o_wr_done    = done_q;
	assign o_wr_refused = refused_q;

	srw_mem #(
		.W     (srw_pkg::BYTE_W),
		.DEPTH (srw_pkg::MEM_DEPTH),
		.AW    (srw_pkg::ADDR_W)
	) u_array (
		.i_ref_clk (i_ref_clk),
		.i_we      (mem_we && !i_wr_start),
		.i_waddr   ({page_q, off_q}),
		.i_wdata   (i_wr_data),
		.i_raddr   (i_rd_addr),
		.o_rdata   (o_rd_data)
	);

	sequence s_hold_done;
		state_q == srw_pkg::ST_HOLD && tick && tmr_q == RST_LAST && !cause;
	endsequence

	sequence s_wdog_done;
		state_q == srw_pkg::ST_RUN && tick && tmr_q == WDOG_LAST && !cause && !kick;
	endsequence

	a_supply_low_rst: assert property (pins_s2_q.supply_low |=> o_rst.rst_hi_oe && o_rst.rst_n_oe)
		else $error("supply low did not assert both resets");
	a_manual_rst: assert property (!mr_level |=> o_rst.rst_n_oe[*2])
		else $error("manual reset did not assert reset");
	a_manual_hold: assert property (!mr_level ##1 mr_level |-> o_rst.rst_n_oe && state_q != srw_pkg::ST_RUN)
		else $error("manual reset release dropped reset at once");
	a_pin_rst: assert property (ext_low |=> state_q == srw_pkg::ST_ASSERT && o_rst.rst_n_oe)
		else $error("outside reset pull not honoured");
	a_timeout_end: assert property (s_hold_done |=> state_q == srw_pkg::ST_RUN ##0 !o_rst.rst_n_oe)
		else $error("reset timeout did not release");
	a_run_entry: assert property ($rose(state_q == srw_pkg::ST_RUN) |-> $past(tmr_q) == RST_LAST)
		else $error("reset released before full timeout");
	a_wdog_fire: assert property (s_wdog_done |=> o_rst.rst_hi_oe && state_q == srw_pkg::ST_HOLD)
		else $error("watchdog expiry did not assert reset");
	a_kick_clear: assert property (state_q == srw_pkg::ST_RUN && kick && !cause |=> tmr_q == '0 && presc_q == '0)
		else $error("kick did not restart watchdog interval");
	a_run_restart: assert property ($rose(state_q == srw_pkg::ST_RUN) |-> tmr_q == '0 && presc_q == '0)
		else $error("watchdog not restarted when reset ended");
	a_wp_block: assert property (i_wr_valid && pins_s2_q.write_protect |-> !mem_we ##1 o_wr_refused)
		else $error("write accepted while protected");
	a_low_block: assert property (i_wr_valid && pins_s2_q.supply_low |-> !mem_we ##1 o_wr_refused && !o_wr_done)
		else $error("write accepted while supply low");
	a_page_wrap: assert property (mem_we && !i_wr_start && off_q == 4'hF |=> off_q == 4'h0 && $stable(page_q))
		else $error("page offset did not wrap inside page");

endmodule

/* File: verif/srw_host_model.sv */
// Purpose: Host controller model that kicks the watchdog and sees both reset pins.
// Assumes: The high reset pin has a pull-down and the low reset pin a pull-up.
// Notes:   The low reset pin is pulled low only while the bench asks for it.
`timescale 1ns/1ns
module srw_host_model (
	input  wire logic              i_ref_clk,
	input  wire logic              i_kick_req,
	input  wire logic              i_pull_req,
	input  wire srw_pkg::srw_rst_s i_rst,
	output logic                   o_kick,
	output logic                   o_rst_hi_lvl,
	output logic                   o_rst_n_lvl
);
	initial o_kick = 1'b0;

	always @(posedge i_ref_clk)
		if (i_kick_req)
			o_kick <= ~o_kick;

	assign o_rst_n_lvl  = !(i_pull_req || (i_rst.rst_n_oe && !i_rst.rst_n_out));
	assign o_rst_hi_lvl = i_rst.rst_hi_oe && i_rst.rst_hi_out;
endmodule

/* File: verif/tb_srw_supervisor.sv */
// Purpose: Self-checking bench for reset timing, watchdog and write gating.
// Assumes: A short tick of 4 clocks keeps every timeout small.
// Notes:   Reset is judged on the resolved pin levels seen by the host.
`timescale 1ns/1ns
module tb_srw_supervisor;
	localparam int TICKS   = 4;
	localparam int RST_CYC = srw_pkg::RST_TICKS * TICKS;
	localparam int WD_CYC  = srw_pkg::WDOG_TICKS * TICKS;
	localparam int DB_CYC  = srw_pkg::DEBOUNCE_TICKS * TICKS;

	logic               i_ref_clk;
	logic               i_rst;
	srw_pkg::srw_pins_s pins;
	srw_pkg::srw_rst_s  rst_o;
	logic               supply_low;
	logic               mr_n;
	logic               wp;
	logic               sda;
	logic               wr_start;
	logic               wr_valid;
	logic [7:0]         wr_addr;
	logic [7:0]         wr_data;
	logic [7:0]         rd_addr;
	logic [7:0]         rd_data;
	logic               wr_done;
	logic               wr_refused;
	logic               kick_req;
	logic               pull_req;
	logic               kick;
	logic               hi_lvl;
	logic               n_lvl;
	int                 n_fail;
	int                 comparisons;

	assign pins = {supply_low, mr_n, n_lvl, kick, sda, wp};

	srw_supervisor #(.TICK_CYCLES(TICKS), .WDOG_ON_SDA(1'b0)) i_srw_supervisor (
		.i_ref_clk    (i_ref_clk),
		.i_rst        (i_rst),
		.i_pins       (pins),
		.i_wr_start   (wr_start),
		.i_wr_addr    (wr_addr),
		.i_wr_valid   (wr_valid),
		.i_wr_data    (wr_data),
		.i_rd_addr    (rd_addr),
		.o_rst        (rst_o),
		.o_wr_done    (wr_done),
		.o_wr_refused (wr_refused),
		.o_rd_data    (rd_data)
	);

	srw_host_model i_srw_host_model (
		.i_ref_clk    (i_ref_clk),
		.i_kick_req   (kick_req),
		.i_pull_req   (pull_req),
		.i_rst        (rst_o),
		.o_kick       (kick),
		.o_rst_hi_lvl (hi_lvl),
		.o_rst_n_lvl  (n_lvl)
	);

	initial
	begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic step(input int n = 1);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Waits until both pins show the wanted state and checks the cycle count.
	task automatic wait_rst(input logic act, input int lo, input int hi);
		int k;
		k = 0;
		while ({hi_lvl, n_lvl} !== (act ? 2'b10 : 2'b01) && k <= hi)
		begin
			step();
			k++;
		end
		chk("reset change in window", 8'h01, 8'(k >= lo && k <= hi));
		if (k > hi)
			print_verdict();
	endtask

	task automatic hold_rst(input logic act, input int n);
		int bad;
		bad = 0;
		repeat (n)
		begin
			step();
			if ({hi_lvl, n_lvl} !== (act ? 2'b10 : 2'b01))
				bad = 1;
		end
		chk("reset steady", 8'h00, 8'(bad));
	endtask

	// Leaves the valid strobe high so bytes can follow back to back.
	task automatic wr(input logic [7:0] d, input logic ok);
		wr_valid = 1'b1;
		wr_data = d;
		step();
		chk("write done", {7'h00, ok}, {7'h00, wr_done});
		chk("write refused", {7'h00, !ok}, {7'h00, wr_refused});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		rd_addr = a;
		step();
		chk("read data", exp, rd_data);
	endtask

	task automatic set_ptr(input logic [7:0] a);
		wr_start = 1'b1;
		wr_addr = a;
		step();
		wr_start = 1'b0;
	endtask

	task automatic t_power;
		step(4);
		chk("reset pins on low supply", 8'h02, {6'h00, hi_lvl, n_lvl});
		wr(8'h11, 1'b0);
		wr_valid = 1'b0;
		supply_low = 1'b0;
		wait_rst(1'b0, RST_CYC, RST_CYC + 6);
	endtask

	task automatic t_write;
		set_ptr(8'h3E);
		wr(8'hA1, 1'b1);
		wr(8'hA2, 1'b1);
		wr(8'hA3, 1'b1);
		wr_valid = 1'b0;
		rd(8'h3E, 8'hA1);
		rd(8'h3F, 8'hA2);
		rd(8'h30, 8'hA3);
		wp = 1'b1;
		set_ptr(8'h30);
		step(3);
		wr(8'h5C, 1'b0);
		wr_valid = 1'b0;
		rd(8'h30, 8'hA3);
		wp = 1'b0;
		step(3);
		wr(8'h5D, 1'b1);
		wr_valid = 1'b0;
		rd(8'h30, 8'h5D);
	endtask

	task automatic t_manual;
		mr_n = 1'b0;
		step(DB_CYC / 2);
		mr_n = 1'b1;
		hold_rst(1'b0, 3 * DB_CYC);
		mr_n = 1'b0;
		wait_rst(1'b1, DB_CYC - 4, DB_CYC + 10);
		hold_rst(1'b1, 2 * RST_CYC);
		mr_n = 1'b1;
		wait_rst(1'b0, RST_CYC + DB_CYC - 4, RST_CYC + DB_CYC + 12);
	endtask

	task automatic t_pin;
		step(5);
		pull_req = 1'b1;
		wait_rst(1'b1, 2, 8);
		step(100);
		pull_req = 1'b0;
		wait_rst(1'b0, RST_CYC - 110, RST_CYC + 6);
	endtask

	task automatic kick_once;
		kick_req = 1'b1;
		step();
		kick_req = 1'b0;
	endtask

	task automatic t_wdog;
		repeat (4)
		begin
			kick_once();
			hold_rst(1'b0, WD_CYC / 2);
		end
		kick_once();
		wait_rst(1'b1, WD_CYC - 2, WD_CYC + 10);
		wait_rst(1'b0, RST_CYC - 2, RST_CYC + 2);
		hold_rst(1'b0, WD_CYC / 2);
		// A data line edge must not restart the watchdog while the kick input is the source.
		sda = 1'b0;
		wait_rst(1'b1, WD_CYC / 2 - 2, WD_CYC / 2 + 4);
	endtask

	initial
	begin
		i_rst = 1'b1;
		supply_low = 1'b1;
		mr_n = 1'b1;
		wp = 1'b0;
		sda = 1'b1;
		wr_start = 1'b0;
		wr_valid = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		rd_addr = 8'h00;
		kick_req = 1'b0;
		pull_req = 1'b0;
		n_fail = 0;
		comparisons = 0;
		step(2);
		i_rst = 1'b0;
		t_power();
		t_write();
		t_manual();
		t_pin();
		t_wdog();
		print_verdict();
	end
endmodule
